// *** cpc_pkg.sv ***
// package for cpu performance counter block: events, channels, constants
// Operation
// - branch taken adds two to counter
// - counters run only on cpu clock
// - 32-bit counters, pairs chain to 64
// - extension enable on channels one and three
// - overflow detected and shown on outputs
// - uncached cacheable-area access still counts cacheable
// - cache-on counting may under or over count
// - non-realtime trace makes results unreliable
// - separate read and write cache access, miss
// - request, response and elapsed cycle counts
// - host initialize clears all counters
package cpc_pkg;
	localparam int CPC_NUM_CH     = 4;
	localparam int CPC_CNT_W      = 32;
	localparam int CPC_SEL_W      = 4;
	localparam int CPC_EXT_PAIRS  = 2;
	localparam logic [3:0] CPC_BRANCH_INC = 4'h2;
	localparam logic [3:0] CPC_UNIT_INC   = 4'h1;
	localparam logic [3:0] CPC_ZERO_INC   = 4'h0;
	typedef enum logic [3:0] {
		CPC_EV_NONE      = 4'h0,
		CPC_EV_BRANCH    = 4'h1,
		CPC_EV_OC_ACC_RD = 4'h2,
		CPC_EV_OC_ACC_WR = 4'h3,
		CPC_EV_OC_MIS_RD = 4'h4,
		CPC_EV_OC_MIS_WR = 4'h5,
		CPC_EV_BUS_REQ   = 4'h6,
		CPC_EV_BUS_RSP   = 4'h7,
		CPC_EV_CYCLE     = 4'h8
	} cpc_event_t;
endpackage

// *** cpc_counter.sv ***
// one 32-bit result counter with carry out and sticky overflow
`timescale 1ns/1ps
module cpc_counter #(
	parameter int WIDTH = 32
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             init,
	input  wire logic [3:0]       inc,
	input  wire logic             carry_in_en,
	input  wire logic             carry_in,
	output logic [WIDTH-1:0]      count_r,
	output logic                  carry_r,
	output logic                  ovf_r
);
	logic [WIDTH-1:0] count_nxt;
	logic             carry_nxt;
	logic             ovf_nxt;
	logic [WIDTH:0]   sum;
	logic [WIDTH-1:0] add;
	initial begin
		if (WIDTH < 4) $error("cpc_counter width too small");
	end
	always_comb begin
		add = carry_in_en ? {{(WIDTH-1){1'b0}}, carry_in} : {{(WIDTH-4){1'b0}}, inc};
		sum = {1'b0, count_r} + {1'b0, add};
		count_nxt = sum[WIDTH-1:0];
		carry_nxt = sum[WIDTH];
		ovf_nxt   = ovf_r | sum[WIDTH];
		if (init) begin
			count_nxt = '0;
			carry_nxt = 1'b0;
			ovf_nxt   = 1'b0;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= '0;
			carry_r <= 1'b0;
			ovf_r   <= 1'b0;
		end else begin
			count_r <= count_nxt;
			carry_r <= carry_nxt;
			ovf_r   <= ovf_nxt;
		end
	end
endmodule

// *** cpc_top.sv ***
// cpu performance counters: event selection, chaining, overflow
`timescale 1ns/1ps
module cpc_top
	import cpc_pkg::*;
#(
	parameter int NUM_CH = cpc_pkg::CPC_NUM_CH,
	parameter int CNT_W  = cpc_pkg::CPC_CNT_W
) (
	input  wire logic                                    clock,
	input  wire logic                                    rst_n,
	input  wire logic                                    init,
	input  wire logic [NUM_CH*cpc_pkg::CPC_SEL_W-1:0]    event_sel,
	input  wire logic                                    ext_en_one,
	input  wire logic                                    ext_en_three,
	input  wire logic                                    ev_branch,
	input  wire logic                                    ev_oc_acc_rd,
	input  wire logic                                    ev_oc_acc_wr,
	input  wire logic                                    ev_oc_mis_rd,
	input  wire logic                                    ev_oc_mis_wr,
	input  wire logic                                    ev_cacheable_area,
	input  wire logic                                    ev_bus_req,
	input  wire logic                                    ev_bus_rsp,
	output logic [NUM_CH*CNT_W-1:0]                      count_out,
	output logic [NUM_CH-1:0]                            ovf_out
);
	import cpc_pkg::*;
	initial begin
		if (NUM_CH != CPC_NUM_CH || CNT_W < $bits(CPC_BRANCH_INC)) begin
			$error("cpc_top needs four channels of at least four bits");
		end
	end
	logic [3:0]           inc      [NUM_CH];
	logic [NUM_CH-1:0]    cin_en;
	logic [NUM_CH-1:0]    carry;
	logic [NUM_CH-1:0]    ovf_raw;
	logic [CNT_W-1:0]     cnt      [NUM_CH];
	logic [NUM_CH-1:0]    ovf_nxt;
	logic [NUM_CH-1:0]    ovf_r;
	logic                 ext_one_r;
	logic                 ext_three_r;
	logic                 ext_one_nxt;
	logic                 ext_three_nxt;

	// extension only changes at initialize so a live pair never splits mid-count
	always_comb begin
		ext_one_nxt   = ext_one_r;
		ext_three_nxt = ext_three_r;
		if (init) begin
			ext_one_nxt   = ext_en_one;
			ext_three_nxt = ext_en_three;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ext_one_r   <= 1'b0;
			ext_three_r <= 1'b0;
		end else begin
			ext_one_r   <= ext_one_nxt;
			ext_three_r <= ext_three_nxt;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			case (cpc_event_t'(event_sel[i*CPC_SEL_W +: CPC_SEL_W]))
				CPC_EV_BRANCH:    inc[i] = ev_branch ? CPC_BRANCH_INC : CPC_ZERO_INC;
				// cacheable area counted even when page attribute bars caching
				CPC_EV_OC_ACC_RD: inc[i] = (ev_oc_acc_rd & ev_cacheable_area) ? CPC_UNIT_INC : CPC_ZERO_INC;
				CPC_EV_OC_ACC_WR: inc[i] = (ev_oc_acc_wr & ev_cacheable_area) ? CPC_UNIT_INC : CPC_ZERO_INC;
				CPC_EV_OC_MIS_RD: inc[i] = ev_oc_mis_rd ? CPC_UNIT_INC : CPC_ZERO_INC;
				CPC_EV_OC_MIS_WR: inc[i] = ev_oc_mis_wr ? CPC_UNIT_INC : CPC_ZERO_INC;
				CPC_EV_BUS_REQ:   inc[i] = ev_bus_req ? CPC_UNIT_INC : CPC_ZERO_INC;
				CPC_EV_BUS_RSP:   inc[i] = ev_bus_rsp ? CPC_UNIT_INC : CPC_ZERO_INC;
				CPC_EV_CYCLE:     inc[i] = CPC_UNIT_INC;
				default:          inc[i] = CPC_ZERO_INC;
			endcase
		end
		// upper halves of a chained pair take only the lower half's carry
		cin_en = '0;
		cin_en[1] = ext_one_r;
		cin_en[3] = ext_three_r;
	end

	// event inputs are same-clock core strobes, so no synchroniser.
	// counts are raw: trace stalls and cache-on skew are not corrected
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		cpc_counter #(
			.WIDTH(CNT_W)
		) u_cnt (
			.clock      (clock),
			.rst_n      (rst_n),
			.init       (init),
			.inc        (inc[g]),
			.carry_in_en(cin_en[g]),
			.carry_in   ((g % 2 == 1) ? carry[g-(g%2)] : 1'b0),
			.count_r    (cnt[g]),
			.carry_r    (carry[g]),
			.ovf_r      (ovf_raw[g])
		);
	end

	// a lower half wrapping inside a chain is not an overflow
	always_comb begin
		ovf_nxt = ovf_raw;
		if (ext_one_r) ovf_nxt[0] = 1'b0;
		if (ext_three_r) ovf_nxt[2] = 1'b0;
		if (ext_one_r) ovf_nxt[1] = ovf_raw[1];
		if (init) ovf_nxt = '0;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ovf_r     <= '0;
			count_out <= '0;
		end else begin
			ovf_r <= ovf_nxt;
			for (int i = 0; i < NUM_CH; i++) begin
				count_out[i*CNT_W +: CNT_W] <= init ? '0 : cnt[i];
			end
		end
	end
	assign ovf_out = ovf_r;
endmodule

// *** cpc_top_chk.sv ***
// port assertions for the performance counter top
`timescale 1ns/1ps
module cpc_top_chk #(
	parameter int NUM_CH = 4,
	parameter int CNT_W  = 32
) (
	input wire logic                    clock,
	input wire logic                    rst_n,
	input wire logic                    init,
	input wire logic [NUM_CH*4-1:0]     event_sel,
	input wire logic                    ev_branch,
	input wire logic                    ev_oc_acc_rd,
	input wire logic                    ev_oc_acc_wr,
	input wire logic                    ev_cacheable_area,
	input wire logic                    ev_bus_req,
	input wire logic                    ev_bus_rsp,
	input wire logic [NUM_CH*CNT_W-1:0] count_out,
	input wire logic [NUM_CH-1:0]       ovf_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire [CNT_W-1:0] c0 = count_out[CNT_W-1:0];
	wire [3:0]  s0 = event_sel[3:0];
	// no init on the event edge nor the one after, so the step reaches count_out
	sequence s_quiet;
		!init ##1 !init;
	endsequence
	// the sum is taken at counter width, so a wrap still matches
	property p_add(logic cause, logic [CNT_W-1:0] d);
		cause ##0 s_quiet |=> c0 == $past(c0) + d;
	endproperty
	a_branch_two: assert property (p_add(ev_branch && s0 == 4'h1, CNT_W'(4'h2)))
		else $error("branch step wrong");
	a_uncached_acc: assert property (p_add(ev_oc_acc_rd && ev_cacheable_area && s0 == 4'h2,
		CNT_W'(4'h1)))
		else $error("cacheable read access not counted");
	a_wr_split: assert property (p_add(!(ev_oc_acc_wr && ev_cacheable_area) && s0 == 4'h3,
		CNT_W'(4'h0)))
		else $error("write access count moved without write");
	a_req_count: assert property (p_add(ev_bus_req && s0 == 4'h6, CNT_W'(4'h1)))
		else $error("request count wrong");
	a_rsp_idle: assert property (p_add(!ev_bus_rsp && s0 == 4'h7, CNT_W'(4'h0)))
		else $error("response count moved without response");
	a_cycle_count: assert property (p_add(s0 == 4'h8, CNT_W'(4'h1)))
		else $error("elapsed cycle count wrong");
	a_init_clear: assert property (init |=> count_out == '0 && ovf_out == '0)
		else $error("init did not clear");
	a_ovf_sticky: assert property (ovf_out[0] && !init |=> ovf_out[0])
		else $error("overflow flag dropped");
endmodule

// *** cpc_top_test.sv ***
// testbench: random events against a counting model
`timescale 1ns/1ps
module cpc_top_test;
	import cpc_pkg::*;
	logic         clock = 0, rst_n = 0, init = 0, ext_en_one = 0, ext_en_three = 0, ca = 0, chk = 0;
	logic [15:0]  event_sel = '0;
	logic [6:0]   ev = '0;
	logic [127:0] count_out;
	logic [3:0]   ovf_out;
	logic [15:0]  count_n;
	logic [3:0]   ovf_n;
	logic [31:0]  seed = 32'hD25ADD4F;
	logic [31:0]  exp_c [4];
	logic [151:0] q [$];
	int           bad_count = 0, comparisons = 0;
	always #50 clock = ~clock;
	cpc_top cpc_top_i (.clock(clock), .rst_n(rst_n), .init(init), .event_sel(event_sel),
		.ext_en_one(ext_en_one), .ext_en_three(ext_en_three), .ev_branch(ev[0]),
		.ev_oc_acc_rd(ev[1]), .ev_oc_acc_wr(ev[2]), .ev_oc_mis_rd(ev[3]), .ev_oc_mis_wr(ev[4]),
		.ev_cacheable_area(ca), .ev_bus_req(ev[5]), .ev_bus_rsp(ev[6]),
		.count_out(count_out), .ovf_out(ovf_out));
	// narrow twin wraps within a short run, so overflow and pair carries are reached
	cpc_top #(.CNT_W(4)) cpc_top_w4_i (.clock(clock), .rst_n(rst_n), .init(init),
		.event_sel(event_sel), .ext_en_one(ext_en_one), .ext_en_three(ext_en_three),
		.ev_branch(ev[0]), .ev_oc_acc_rd(ev[1]), .ev_oc_acc_wr(ev[2]), .ev_oc_mis_rd(ev[3]),
		.ev_oc_mis_wr(ev[4]), .ev_cacheable_area(ca), .ev_bus_req(ev[5]), .ev_bus_rsp(ev[6]),
		.count_out(count_n), .ovf_out(ovf_n));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [31:0] inc(input logic [3:0] s, input logic [6:0] e, input logic c);
		case (s)
			4'h1: return e[0] ? 32'h2 : 32'h0;
			4'h2, 4'h3: return {31'h0, e[s-1] & c};
			4'h4, 4'h5, 4'h6, 4'h7: return {31'h0, e[s-1]};
			4'h8: return 32'h1;
			default: return 32'h0;
		endcase
	endfunction
	task automatic run(input logic x, input logic fix, input int n);
		logic [15:0] sel;
		logic [15:0] en;
		logic [3:0]  eo;
		@(posedge clock);
		init <= 1'b1;
		ext_en_one <= x;
		ext_en_three <= x;
		ev <= 7'h7F;
		event_sel <= 16'h8888;
		exp_c = '{default: 32'h0};
		repeat (n) begin
			@(posedge clock);
			init <= 1'b0;
			seed = xs(seed);
			sel = fix ? 16'h8888 : seed[31:16];
			ev <= seed[6:0];
			ca <= seed[7];
			event_sel <= sel;
			// chained upper halves only see carries, far off in this short run
			for (int i = 0; i < 4; i++) if (!(x && i[0])) exp_c[i] += inc(sel[4*i+:4], seed[6:0], seed[7]);
		end
		@(posedge clock);
		ev <= '0;
		event_sel <= '0;
		// narrow twin: 4-bit channels, or 8-bit pairs flagged on the upper half
		for (int i = 0; i < 4; i++) begin
			if (x && i[0]) begin
				en[4*i+:4] = exp_c[i-1][7:4];
				eo[i] = exp_c[i-1] > 32'hFF;
			end else begin
				en[4*i+:4] = exp_c[i][3:0];
				eo[i] = !x && exp_c[i] > 32'hF;
			end
		end
		repeat (3) @(posedge clock);
		q.push_back({eo, en, 4'h0, exp_c[3], exp_c[2], exp_c[1], exp_c[0]});
		chk <= 1'b1;
		@(posedge clock);
		chk <= 1'b0;
		$display("test done, extension %0d fixed %0d", x, fix);
	endtask
	always @(posedge clock) begin
		logic [151:0] e;
		if (chk) begin
			e = q.pop_front();
			comparisons += 2;
			if ({ovf_out, count_out} !== e[131:0]) begin
				bad_count++;
				$display("[ERR] counts exp %h got %h", e[131:0], {ovf_out, count_out});
			end
			if ({ovf_n, count_n} !== e[151:132]) begin
				bad_count++;
				$display("[ERR] narrow counts exp %h got %h", e[151:132], {ovf_n, count_n});
			end
		end
	end
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		run(1'b0, 1'b0, 200);
		run(1'b1, 1'b0, 200);
		run(1'b1, 1'b1, 300);
		// reset while counts and flags are set must drop them at once
		@(posedge clock);
		rst_n <= 1'b0;
		q.push_back('0);
		chk <= 1'b1;
		@(posedge clock);
		chk <= 1'b0;
		rst_n <= 1'b1;
		$display("test done, reset with counts held");
		run(1'b0, 1'b1, 20);
		repeat (2) @(posedge clock);
		final_report;
	end
	initial begin
		#1000000;
		bad_count++;
		final_report;
	end
endmodule
bind cpc_top cpc_top_chk #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) cpc_top_chk_i (.clock(clock), .rst_n(rst_n),
	.init(init), .event_sel(event_sel), .ev_branch(ev_branch), .ev_oc_acc_rd(ev_oc_acc_rd),
	.ev_oc_acc_wr(ev_oc_acc_wr), .ev_cacheable_area(ev_cacheable_area),
	.ev_bus_req(ev_bus_req), .ev_bus_rsp(ev_bus_rsp), .count_out(count_out), .ovf_out(ovf_out));
